// File: common/csaie_regs.vh
`ifndef CSAIE_REGS_VH
`define CSAIE_REGS_VH
// ****************************************
// instruction encodings
// ****************************************
`define CSAIE_OP_MUL_HI     7'h01
`define CSAIE_OP_NEG_HI     7'h36
`define CSAIE_OP_CALL_HI    5'h1b
`define CSAIE_OP_NOPX_HI    4'hf
`define CSAIE_OP_IDLE       16'h0000
`define CSAIE_OP_POP        16'h0006
`define CSAIE_OP_PUSH       16'h0005
`define CSAIE_OP_RESET      16'h00ff
// ****************************************
// addressing and status layout
// ****************************************
`define CSAIE_IDX_LIMIT     8'h5f
`define CSAIE_ACC_SPLIT     8'h80
`define CSAIE_ACC_HIGH_BANK 4'hf
`define CSAIE_ST_C          0
`define CSAIE_ST_DIGIT      1
`define CSAIE_ST_Z          2
`define CSAIE_ST_OVF        3
`define CSAIE_ST_N          4
`define CSAIE_PC_STEP       21'h000002
// ****************************************
// quarter phases (one-hot)
// ****************************************
`define CSAIE_Q1            4'h1
`define CSAIE_Q2            4'h2
`define CSAIE_Q3            4'h4
`define CSAIE_Q4            4'h8
`endif

// File: rtl/csaie_return_stack.v
`timescale 1ns/10ps
`include "csaie_regs.vh"
// ****************************************
// return stack, flip-flop storage
// ****************************************
module csaie_return_stack #(
  parameter DEPTH = 31,
  parameter PTRW  = 5,
  parameter AW    = 21
) (
  // clock and reset
  input  wire          clock,
  input  wire          rst_b,
  input  wire          softReset,
  // stack commands
  input  wire          pushEn,
  input  wire          popEn,
  input  wire [AW-1:0] pushData,
  // top view
  output reg  [AW-1:0] topOfStackEntry,
  output reg  [PTRW-1:0] stackPtr
);
  reg [AW-1:0] mem [0:DEPTH-1];
  integer i;

  // level 0 is top; push shifts down, pop shifts up
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < DEPTH; i = i + 1) mem[i] <= {AW{1'b0}};
      stackPtr <= {PTRW{1'b0}};
      topOfStackEntry <= {AW{1'b0}};
    end else if (softReset) begin
      for (i = 0; i < DEPTH; i = i + 1) mem[i] <= {AW{1'b0}};
      stackPtr <= {PTRW{1'b0}};
      topOfStackEntry <= {AW{1'b0}};
    end else if (pushEn) begin
      mem[0] <= pushData;
      for (i = 1; i < DEPTH; i = i + 1) mem[i] <= mem[i-1];
      topOfStackEntry <= pushData;
      if (stackPtr != DEPTH[PTRW-1:0]) stackPtr <= stackPtr + 1'b1;
    end else if (popEn) begin
      for (i = 0; i < DEPTH - 1; i = i + 1) mem[i] <= mem[i+1];
      mem[DEPTH-1] <= {AW{1'b0}};
      topOfStackEntry <= mem[1];
      if (stackPtr != {PTRW{1'b0}}) stackPtr <= stackPtr - 1'b1;
    end
  end
endmodule // csaie_return_stack

// File: rtl/csaie_exec.v
`timescale 1ns/10ps
`include "csaie_regs.vh"
// ****************************************
// execution unit for multiply, negate, stack and call
// ****************************************
module csaie_exec #(
  parameter AW = 21
) (
  // clock and reset
  input  wire          clock,
  input  wire          rst_b,
  // instruction and mode
  input  wire [15:0]   instrWord,
  input  wire          instrValid,
  input  wire          extendedSet,
  // core state inputs
  input  wire [7:0]    workingReg,
  input  wire [3:0]    bankSelectRegister,
  input  wire [AW-1:0] progCounter,
  // data memory read data
  input  wire [7:0]    fileReadData,
  input  wire [7:0]    fsr2Base,
  // data memory write
  output reg  [11:0]   fileAddr,
  output reg           fileAddrIndexed,
  output reg           fileWrite,
  output reg  [7:0]    fileWriteData,
  // product register pair
  output reg  [7:0]    productHighRegister,
  output reg  [7:0]    productLowRegister,
  // status and program counter
  output reg  [4:0]    statusFlags,
  output reg           pcLoad,
  output reg  [AW-1:0] pcNext,
  // stack view and phase
  output reg  [AW-1:0] topOfStackEntry,
  output reg  [4:0]    stackPtr,
  output reg  [3:0]    quarterPhase,
  output reg           instrDone,
  output reg           softResetOut
);
  // ****************************************
  // decode helpers
  // ****************************************
  localparam ST_EXEC  = 2'b01;
  localparam ST_FLUSH = 2'b10;

  reg  [1:0]    state;
  reg  [15:0]   curInstr;
  reg           softReset;
  wire [AW-1:0] stackTop;
  wire [4:0]    stackLevel;
  reg           pushEn;
  reg           popEn;
  reg  [AW-1:0] pushData;
  reg  [AW-1:0] next_pc;
  reg  [11:0]   next_addr;
  reg           next_indexed;
  reg  [8:0]    negSum;
  reg  [4:0]    negLow;
  reg  [15:0]   product;

  // file-address mapping shared by both file instructions
  function [12:0] map_addr;
    input [7:0] f;
    input       a;
    input       ext;
    input [3:0] bank;
    input [7:0] base;
    begin
      if (a)
        map_addr = {1'b0, bank, f};
      else if (ext && f <= `CSAIE_IDX_LIMIT)
        // keep the carry of base plus offset; wrapping would alias the access bank
        map_addr = {1'b1, 4'h0, base} + {5'h00, f};
      else if (f < `CSAIE_ACC_SPLIT)
        map_addr = {1'b0, 4'h0, f};
      else
        map_addr = {1'b0, `CSAIE_ACC_HIGH_BANK, f};
    end
  endfunction

  wire isMul  = (curInstr[15:9] == `CSAIE_OP_MUL_HI);
  wire isNeg  = (curInstr[15:9] == `CSAIE_OP_NEG_HI);
  wire isCall = (curInstr[15:11] == `CSAIE_OP_CALL_HI);
  wire isPop  = (curInstr == `CSAIE_OP_POP);
  wire isPush = (curInstr == `CSAIE_OP_PUSH);
  wire isRst  = (curInstr == `CSAIE_OP_RESET);

  // ****************************************
  // quarter phase ring and instruction latch
  // ****************************************
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      quarterPhase <= `CSAIE_Q1;
      curInstr     <= `CSAIE_OP_IDLE;
      state        <= ST_EXEC;
      instrDone    <= 1'b0;
    end else begin
      quarterPhase <= {quarterPhase[2:0], quarterPhase[3]};
      instrDone    <= quarterPhase[3] && state == ST_EXEC;
      if (quarterPhase[3]) begin
        case (state)
          ST_EXEC: begin
            if (isCall) begin
              state    <= ST_FLUSH;
              curInstr <= `CSAIE_OP_IDLE;
            end else begin
              // unknown or top-nibble-ones words fall through as no-ops
              curInstr <= instrValid ? instrWord : `CSAIE_OP_IDLE;
            end
          end
          ST_FLUSH: begin
            state    <= ST_EXEC;
            curInstr <= instrValid ? instrWord : `CSAIE_OP_IDLE;
          end
          default: state <= ST_EXEC;
        endcase
      end
    end
  end

  // ****************************************
  // combinational datapath
  // ****************************************
  always @* begin
    {next_indexed, next_addr} = map_addr(curInstr[7:0], curInstr[8], extendedSet,
                                         bankSelectRegister, fsr2Base);
    product  = workingReg * fileReadData;
    negSum   = {1'b0, ~fileReadData} + 9'h001;
    negLow   = {1'b0, ~fileReadData[3:0]} + 5'h01;
    next_pc  = progCounter + `CSAIE_PC_STEP +
               {{(AW-12){curInstr[10]}}, curInstr[10:0], 1'b0};
    pushEn   = 1'b0;
    popEn    = 1'b0;
    pushData = progCounter + `CSAIE_PC_STEP;
    if (quarterPhase[1] && state == ST_EXEC && (isPush || isCall))
      pushEn = 1'b1;
    if (quarterPhase[2] && state == ST_EXEC && isPop)
      popEn = 1'b1;
  end

  // ****************************************
  // register writes at the proper quarter
  // ****************************************
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fileAddr            <= 12'h000;
      fileAddrIndexed     <= 1'b0;
      fileWrite           <= 1'b0;
      fileWriteData       <= 8'h00;
      productHighRegister <= 8'h00;
      productLowRegister  <= 8'h00;
      statusFlags         <= 5'h00;
      pcLoad              <= 1'b0;
      pcNext              <= {AW{1'b0}};
      softReset           <= 1'b0;
      softResetOut        <= 1'b0;
      topOfStackEntry     <= {AW{1'b0}};
      stackPtr            <= 5'h00;
    end else if (softReset) begin
      // restore master-clear values in this block; the phase ring and instruction latch are not reset
      fileAddr            <= 12'h000;
      fileAddrIndexed     <= 1'b0;
      fileWrite           <= 1'b0;
      fileWriteData       <= 8'h00;
      productHighRegister <= 8'h00;
      productLowRegister  <= 8'h00;
      statusFlags         <= 5'h00;
      pcLoad              <= 1'b0;
      pcNext              <= {AW{1'b0}};
      softReset           <= 1'b0;
      softResetOut        <= 1'b0;
      topOfStackEntry     <= {AW{1'b0}};
      stackPtr            <= 5'h00;
    end else begin
      topOfStackEntry <= stackTop;
      stackPtr        <= stackLevel;
      fileWrite       <= 1'b0;
      pcLoad          <= 1'b0;
      // reset starts in quarter two
      softReset       <= quarterPhase[1] && state == ST_EXEC && isRst;
      softResetOut    <= quarterPhase[1] && state == ST_EXEC && isRst;
      if (quarterPhase[0] && state == ST_EXEC && (isMul || isNeg)) begin
        fileAddr        <= next_addr;
        fileAddrIndexed <= next_indexed;
      end
      if (quarterPhase[3] && state == ST_EXEC) begin
        if (isMul) begin
          // flags left alone, zero result not flagged
          productHighRegister <= product[15:8];
          productLowRegister  <= product[7:0];
        end
        if (isNeg) begin
          fileWrite     <= 1'b1;
          fileWriteData <= negSum[7:0];
          statusFlags[`CSAIE_ST_C]  <= negSum[8];
          statusFlags[`CSAIE_ST_DIGIT] <= negLow[4];
          statusFlags[`CSAIE_ST_Z]  <= (negSum[7:0] == 8'h00);
          statusFlags[`CSAIE_ST_N]  <= negSum[7];
          statusFlags[`CSAIE_ST_OVF] <= (fileReadData == 8'h80);
        end
        if (isCall) begin
          pcLoad <= 1'b1;
          pcNext <= next_pc;
        end
      end
    end
  end

  csaie_return_stack #(
    .DEPTH (31),
    .PTRW  (5),
    .AW    (AW)
  ) uStack (
    .clock           (clock),
    .rst_b           (rst_b),
    .softReset       (softReset),
    .pushEn          (pushEn),
    .popEn           (popEn),
    .pushData        (pushData),
    .topOfStackEntry (stackTop),
    .stackPtr        (stackLevel)
  );
endmodule // csaie_exec

// File: bench/csaie_exec_checker.sv
`timescale 1ns/10ps
`include "csaie_regs.vh"
// ********
// execution unit port checker
// ********
module csaie_exec_checker #(
  parameter AW = 21
) (
  // clock and reset
  input wire logic          clock,
  input wire logic          rst_b,
  // inputs
  input wire logic [15:0]   instrWord,
  input wire logic          instrValid,
  input wire logic [7:0]    workingReg,
  input wire logic [AW-1:0] progCounter,
  input wire logic [7:0]    fileReadData,
  // outputs
  input wire logic          fileWrite,
  input wire logic [7:0]    fileWriteData,
  input wire logic [7:0]    productHighRegister,
  input wire logic [7:0]    productLowRegister,
  input wire logic [4:0]    statusFlags,
  input wire logic          pcLoad,
  input wire logic [AW-1:0] pcNext,
  input wire logic [AW-1:0] topOfStackEntry,
  input wire logic [4:0]    stackPtr,
  input wire logic [3:0]    quarterPhase,
  input wire logic          instrDone,
  input wire logic          softResetOut
);
  logic        callPend;
  logic [15:0] heldWord;
  logic        flushing;
  wire         take = quarterPhase == `CSAIE_Q4 && instrValid && !callPend;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  // capture tracking; the flush cycle of a call takes nothing, so mask it
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      callPend <= 1'b0;
      heldWord <= 16'h0000;
    end else if (take) begin
      callPend <= instrWord[15:11] == `CSAIE_OP_CALL_HI;
      heldWord <= instrWord;
    end else if (quarterPhase == `CSAIE_Q4) begin
      callPend <= 1'b0;
    end
  end

  // the cycle after a call's own cycle is a flush and reports no completion
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flushing <= 1'b0;
    end else if (quarterPhase == `CSAIE_Q4) begin
      flushing <= callPend;
    end
  end

  property p_done;
    1'b1 |=> instrDone == ($past(quarterPhase) == `CSAIE_Q4 && !$past(flushing));
  endproperty
  a_done: assert property (p_done) else $error("completion pulse out of step");

  property p_phase;
    1'b1 |=> quarterPhase == {$past(quarterPhase[2:0]), $past(quarterPhase[3])};
  endproperty
  a_phase: assert property (p_phase) else $error("quarter phase out of step");
  property p_mul;
    take && instrWord[15:9] == `CSAIE_OP_MUL_HI |-> ##[5:6]
      {productHighRegister, productLowRegister} == workingReg * fileReadData;
  endproperty
  a_mul: assert property (p_mul) else $error("product pair wrong");
  property p_mul_flags;
    take && instrWord[15:9] == `CSAIE_OP_MUL_HI |-> ##3 $stable(statusFlags) [*5];
  endproperty
  a_mul_flags: assert property (p_mul_flags) else $error("multiply moved flags");
  property p_neg;
    take && instrWord[15:9] == `CSAIE_OP_NEG_HI |-> ##[4:6]
      fileWrite && fileWriteData == 8'h00 - fileReadData;
  endproperty
  a_neg: assert property (p_neg) else $error("negate result wrong");
  property p_push;
    take && instrWord == `CSAIE_OP_PUSH |-> ##[2:6]
      topOfStackEntry == progCounter + `CSAIE_PC_STEP;
  endproperty
  a_push: assert property (p_push) else $error("push value wrong");
  property p_pop;
    take && instrWord == `CSAIE_OP_POP && stackPtr != 5'h00 |-> ##5
      stackPtr == $past(stackPtr, 5) - 5'h01;
  endproperty
  a_pop: assert property (p_pop) else $error("pop depth wrong");
  property p_call;
    take && instrWord[15:11] == `CSAIE_OP_CALL_HI |-> ##[5:6] pcLoad &&
      pcNext == progCounter + `CSAIE_PC_STEP + {{9{heldWord[10]}}, heldWord[10:0], 1'b0};
  endproperty
  a_call: assert property (p_call) else $error("call target wrong");
  property p_reset;
    take && instrWord == `CSAIE_OP_RESET |-> ##[2:7] softResetOut ##2
      (stackPtr == 5'h00 && statusFlags == 5'h00 && productLowRegister == 8'h00);
  endproperty
  a_reset: assert property (p_reset) else $error("soft reset incomplete");
  property p_nop;
    take && instrWord[15:12] == `CSAIE_OP_NOPX_HI |-> ##3
      (!fileWrite && !pcLoad && $stable(productLowRegister)) [*4];
  endproperty
  a_nop: assert property (p_nop) else $error("no-op changed state");
endmodule // csaie_exec_checker

bind csaie_exec csaie_exec_checker #(.AW(AW)) exec_chk (.*);

// File: bench/csaie_exec_test.sv
`timescale 1ns/10ps
`include "csaie_regs.vh"
// ********
// self-checking bench, execution unit
// ********
module csaie_exec_test;
  logic        clock, rst_b, instrValid, extendedSet, fileAddrIndexed, fileWrite;
  logic        pcLoad, instrDone, softResetOut;
  logic [15:0] instrWord, pr0;
  logic [7:0]  workingReg, fileReadData, fsr2Base, fileWriteData, wrSeen, fa, d;
  logic [7:0]  productHighRegister, productLowRegister;
  logic [3:0]  bankSelectRegister, quarterPhase;
  logic [20:0] progCounter, pcNext, topOfStackEntry, pcSeen;
  logic [11:0] fileAddr;
  logic [12:0] ea;
  logic [10:0] n;
  logic [4:0]  statusFlags, stackPtr, fl0, sp0;
  integer      failures, cmpCount, seed, k, wrCnt, w0;

  csaie_exec dut (.*);

  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // pulses last one clock, so latch them for later checks
  always @(posedge clock) begin
    if (fileWrite === 1'b1) begin
      wrSeen <= fileWriteData;
      wrCnt <= wrCnt + 1;
    end
    if (pcLoad === 1'b1) pcSeen <= pcNext;
  end

  task chk(input bit ok, input string msg);
    cmpCount++;
    if (!ok) begin
      failures++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask

  // present on the Q3 edge, captured on Q4, then follower word, then idle
  task run(input logic [15:0] w, input logic [15:0] nxt);
    integer i;
    i = 0;
    @(negedge clock);
    while (quarterPhase !== `CSAIE_Q3 && i < 8) begin
      @(negedge clock);
      i++;
    end
    @(posedge clock);
    instrWord <= w;
    instrValid <= 1'b1;
    @(posedge clock);
    instrWord <= nxt;
    repeat (4) @(posedge clock);
    instrValid <= 1'b0;
    repeat (10) @(posedge clock);
    @(negedge clock);
  endtask

  function automatic logic [12:0] expAddr(input logic [7:0] f, input logic a, x,
                                          input logic [3:0] b, input logic [7:0] base);
    if (a) return {1'b0, b, f};
    if (x && f <= `CSAIE_IDX_LIMIT) return {1'b1, {4'h0, base} + {4'h0, f}};
    return {1'b0, f >= `CSAIE_ACC_SPLIT ? `CSAIE_ACC_HIGH_BANK : 4'h0, f};
  endfunction

  // flags {sign,overflow,zero,nibble carry,carry}; carries only on a zero operand or nibble
  function automatic logic [4:0] negFlags(input logic [7:0] f);
    logic [7:0] r;
    r = 8'h00 - f;
    return {r[7], f == 8'h80, r == 8'h00, f[3:0] == 4'h0, f == 8'h00};
  endfunction

  task report_and_stop;
    if (failures == 0 && cmpCount > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // hang guard, far beyond the run's length
  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    report_and_stop;
  end

  initial begin
    seed = 29;
    failures = 0;
    cmpCount = 0;
    wrCnt = 0;
    rst_b = 1'b0;
    instrValid = 1'b0;
    instrWord = 16'h0000;
    extendedSet = 1'b0;
    workingReg = 8'h00;
    fileReadData = 8'h00;
    fsr2Base = 8'h00;
    bankSelectRegister = 4'h0;
    progCounter = 21'h000000;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    // multiply in every addressing mode, f at the indexed limit and just past it
    for (k = 0; k < 8; k++) begin
      fa = k == 2 ? 8'h5f : k == 6 ? 8'h60 : $random(seed);
      d = $random(seed);
      fl0 = statusFlags;
      @(posedge clock);
      workingReg <= $random(seed);
      fileReadData <= d;
      fsr2Base <= $random(seed);
      bankSelectRegister <= $random(seed);
      extendedSet <= k[1];
      run({`CSAIE_OP_MUL_HI, k[0], fa}, 16'h0000);
      ea = expAddr(fa, k[0], k[1], bankSelectRegister, fsr2Base);
      chk({productHighRegister, productLowRegister} === workingReg * d, "product");
      chk(statusFlags === fl0, "multiply flags");
      chk({fileAddrIndexed, fileAddr} === ea, "address");
    end
    // negate: zero, most negative, zero low nibble, then random
    for (k = 0; k < 6; k++) begin
      d = k == 0 ? 8'h00 : k == 1 ? 8'h80 : k == 2 ? 8'h30 : $random(seed);
      @(posedge clock);
      fileReadData <= d;
      w0 = wrCnt;
      run({`CSAIE_OP_NEG_HI, 1'b1, 8'h20}, 16'h0000);
      chk(wrCnt == w0 + 1, "negate write pulse");
      chk(wrSeen === 8'h00 - d, "negate data");
      chk(statusFlags === negFlags(d), "negate flags");
    end
    pr0 = {productHighRegister, productLowRegister};
    fl0 = statusFlags;
    sp0 = stackPtr;
    w0 = wrCnt;
    run({`CSAIE_OP_NOPX_HI, 12'h5a3}, `CSAIE_OP_IDLE);
    chk({productHighRegister, productLowRegister, statusFlags, stackPtr} === {pr0, fl0, sp0},
        "no-op");
    chk(wrCnt == w0, "no-op write");
    // two pushes, then a pop back to the first
    @(posedge clock);
    progCounter <= 21'h000124;
    run(`CSAIE_OP_PUSH, 16'h0000);
    chk(topOfStackEntry === 21'h000126, "push");
    sp0 = stackPtr;
    @(posedge clock);
    progCounter <= 21'h01a3f0;
    run(`CSAIE_OP_PUSH, 16'h0000);
    chk(stackPtr === sp0 + 5'h1 && topOfStackEntry === 21'h01a3f2, "push depth");
    run(`CSAIE_OP_POP, 16'h0000);
    chk(stackPtr === sp0 && topOfStackEntry === 21'h000126, "pop");
    // call at both offset ends; a push offered at the Q4 ending the call's own cycle is dropped
    for (k = 0; k < 3; k++) begin
      n = k == 0 ? 11'h400 : k == 1 ? 11'h3ff : $random(seed);
      @(posedge clock);
      progCounter <= {4'h1, 16'($random(seed)), 1'b0};
      sp0 = stackPtr;
      run({`CSAIE_OP_CALL_HI, n}, `CSAIE_OP_PUSH);
      chk(topOfStackEntry === progCounter + 21'h2, "return address");
      chk(stackPtr === sp0 + 5'h1, "flush cycle");
      chk(pcSeen === progCounter + 21'h2 + {{9{n[10]}}, n, 1'b0}, "target");
    end
    run(`CSAIE_OP_RESET, 16'h0000);
    chk({productHighRegister, productLowRegister, statusFlags, stackPtr, topOfStackEntry}
        === 47'h0, "soft reset");
    report_and_stop;
  end
endmodule // csaie_exec_test
